/* cma_pkg.sv */
// constants and carrier types shared by the cipher master port adapter
package cma_pkg;

  // cipher clock ceilings and host rate thresholds, in kHz
  localparam int CIPH_MAX_KHZ     = 4000;
  localparam int CIPH_OLD_MAX_KHZ = 3000;
  localparam int WAIT_HOST_KHZ    = 7000;
  localparam int WIDE_AS_HOST_KHZ = 4440;

  // register select codes as latched from the two address bits
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_CMD  = 2'h1;

  // command and status byte values
  localparam logic [7:0] CMD_SOFT_RST  = 8'h00;
  localparam logic [7:0] CMD_LOAD_KEY  = 8'h11;
  localparam logic [7:0] CMD_STOP      = 8'he0;
  localparam logic [7:0] STAT_CLEAR    = 8'h00;
  localparam logic [7:0] STAT_CMD_PEND = 8'h40;
  localparam logic [7:0] STAT_BUSY     = 8'h20;

  // counts and reset values
  localparam logic [3:0] KEY_BYTES    = 4'h8;
  localparam logic [3:0] KEY_LAST     = 4'h1;
  localparam logic [3:0] KEY_NONE     = 4'h0;
  localparam logic       CIPH_CLK_RST = 1'b0;
  localparam logic [7:0] STATUS_RST   = 8'h00;

  typedef struct packed {
    logic       cpu_clk;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       io_read_cmd_n;
    logic       adv_io_write_cmd_n;
    logic       xmit_recv_dir;
    logic       m_io;
    logic       cs_n;
    logic       a2;
    logic       a1;
    logic [7:0] data;
  } cma_host_t;

  typedef struct packed {
    logic port_addr_strobe_n;
    logic port_data_strobe_n;
    logic port_rw_dir;
    logic port_chip_select_n;
    logic reg_sel_bit2;
    logic reg_sel_bit1;
    logic ctl_key_mode_sel;
  } cma_port_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DATA = 4'b1000
  } cma_state_t;

endpackage

/* cma_clk_sync.sv */
// cipher clock divider with per-access phase synchroniser
`timescale 1ns/1ps
module cma_clk_sync
  import cma_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // cpu clock level and events
  input  wire logic cpu_lvl,
  input  wire logic cpu_fall,
  input  wire logic rephase,
  // configuration
  input  wire logic odd_waits,
  input  wire logic div_en,
  // cipher clock
  output logic      cipher_clk
);

  typedef struct packed {
    logic div;
    logic out;
  } cma_sync_t;

  cma_sync_t q;
  cma_sync_t d;

  always_comb begin
    d = q;
    if (rephase) begin
      // forced level puts the strobe release on a falling edge
      d.div = odd_waits;
    end else if (cpu_fall) begin
      d.div = ~q.div;
    end
    // direct mode only suits slow hosts, the divider keeps the ceiling
    d.out = div_en ? d.div : cpu_lvl;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.div <= CIPH_CLK_RST;
      q.out <= CIPH_CLK_RST;
    end else begin
      q <= d;
    end
  end

  assign cipher_clk = q.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rephase_level: assert property (
    rephase && div_en |=> cipher_clk == $past(odd_waits)
  ) else $error("cipher clock not forced to variant level");

  a_divide_toggle: assert property (
    cpu_fall && !rephase && div_en |=> cipher_clk != $past(q.div)
  ) else $error("divided clock failed to toggle");

  a_hold_between: assert property (
    !cpu_fall && !rephase && div_en |=> $stable(q.div)
  ) else $error("divided clock moved without a cpu edge");

endmodule

/* cma_adapter.sv */
// host local bus to cipher processor master port adapter
//
// What this block does
// - read and write strobes become direction plus strobe
// - address strobe is inverted address latch enable
// - register select latched at address strobe rise
// - chip select latched at address strobe rise
// - direction line follows transmit/receive signal
// - maximum mode strobe from I/O read or write
// - minimum mode strobe is OR of read, write
// - cipher clock within ceiling, strobes synchronous
// - fast hosts get cipher clock at half rate
// - one wait on every selected access above threshold
// - all selected accesses use the same wait count
// - strobe release meets falling cipher clock edge
// - re-phase at falling edge ending first state
// - force low for even, high for odd
// - command 00 performs software reset
// - key command: pending status, eight bytes MSB first
// - stop command clears every status flag
`timescale 1ns/1ps
module cma_adapter
  import cma_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // host local bus pins
  input  wire cma_host_t  host_i,
  // configuration straps
  input  wire logic       min_mode,
  input  wire logic       clk_div_en,
  input  wire logic       fast_host,
  // master port pins
  output cma_port_t       port_o,
  output logic            cipher_clk,
  // host ready line
  output logic            host_ready,
  // session tracking
  output logic [7:0]      exp_status,
  output logic [3:0]      key_bytes_left,
  output logic            soft_reset_pulse
);

  typedef struct packed {
    cma_host_t  s1;
    cma_host_t  s2;
    cma_host_t  s3;
    cma_port_t  port;
    logic [1:0] lat_sel;
    logic       lat_cs;
    cma_state_t st;
    logic       synced;
    logic       ready;
    logic [7:0] status;
    logic [3:0] key_left;
    logic       rst_pulse;
  } cma_main_t;

  cma_main_t q;
  cma_main_t d;

  logic cpu_fall;
  logic ale_fall;
  logic ds_now;
  logic ds_prev;
  logic ds_end;
  logic rephase;
  logic our_write;

  // strobe decode, used for the current and the previous sample
  function automatic logic strobe_of(input cma_host_t h,
                                     input logic      mm);
    logic act;
    if (mm) begin
      act = ~(h.rd_n & h.wr_n);
    end else begin
      // advanced write gives the wider low time
      act = ~(h.io_read_cmd_n & h.adv_io_write_cmd_n);
    end
    return act;
  endfunction

  // decoder is only honoured during I/O cycles in minimum mode
  function automatic logic cs_of(input cma_host_t h,
                                 input logic      mm);
    logic sel;
    sel = ~h.cs_n & ~(mm & h.m_io);
    return sel;
  endfunction

  assign cpu_fall = q.s3.cpu_clk & ~q.s2.cpu_clk;
  assign ale_fall = q.s3.ale & ~q.s2.ale;
  assign ds_now   = strobe_of(q.s2, min_mode);
  assign ds_prev  = strobe_of(q.s3, min_mode);
  assign ds_end   = ds_prev & ~ds_now;

  // first falling cpu edge of the access closes the first bus state
  assign rephase  = cpu_fall & (q.st == ST_ADDR) & ~q.synced
                    & cs_of(q.s2, min_mode);

  assign our_write = ds_end & q.lat_cs & q.s3.xmit_recv_dir
                     & (q.st == ST_DATA);

  always_comb begin
    d = q;
    // two flops before any logic reads a pin
    d.s1 = host_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rst_pulse = 1'b0;

    // port pin translation
    d.port.port_addr_strobe_n = ~q.s2.ale;
    d.port.port_data_strobe_n = ~ds_now;
    d.port.port_rw_dir = q.s2.xmit_recv_dir;
    d.port.port_chip_select_n = ~cs_of(q.s2, min_mode);
    d.port.reg_sel_bit2 = q.s2.a2;
    d.port.reg_sel_bit1 = q.s2.a1;
    // multiplexed control mode, address shares the data lines
    d.port.ctl_key_mode_sel = 1'b0;

    // capture at the rising edge of the port address strobe
    if (ale_fall) begin
      d.lat_sel = {q.s2.a2, q.s2.a1};
      d.lat_cs  = cs_of(q.s2, min_mode);
    end

    if (rephase) begin
      d.synced = 1'b1;
    end

    case (q.st)
      ST_IDLE: begin
        d.ready  = 1'b1;
        d.synced = 1'b0;
        if (q.s2.ale) begin
          d.st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!q.s2.ale && ds_now) begin
          if (q.lat_cs && fast_host) begin
            // one wait on every selected access keeps the count odd
            d.ready = 1'b0;
            d.st    = ST_WAIT;
          end else begin
            d.st = ST_DATA;
          end
        end
      end
      ST_WAIT: begin
        if (cpu_fall) begin
          d.ready = 1'b1;
          d.st    = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!ds_now) begin
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st    = ST_IDLE;
        d.ready = 1'b1;
      end
    endcase

    // shadow of the cipher processor session, byte taken at release
    if (our_write) begin
      if (q.lat_sel == SEL_CMD) begin
        case (q.s3.data)
          CMD_SOFT_RST: begin
            d.status    = STAT_CLEAR;
            d.key_left  = KEY_NONE;
            d.rst_pulse = 1'b1;
          end
          CMD_LOAD_KEY: begin
            d.status   = STAT_CMD_PEND;
            d.key_left = KEY_BYTES;
          end
          CMD_STOP: begin
            d.status   = STAT_CLEAR;
            d.key_left = KEY_NONE;
          end
          default: begin
            d.status = q.status;
          end
        endcase
      end else if (q.lat_sel == SEL_DATA && q.key_left != KEY_NONE) begin
        // bytes count down from the most significant one
        d.key_left = q.key_left - KEY_LAST;
        if (q.key_left == KEY_LAST) begin
          d.status = STAT_CLEAR;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q           <= '0;
      q.s1.rd_n   <= 1'b1;
      q.s1.wr_n   <= 1'b1;
      q.s2.rd_n   <= 1'b1;
      q.s2.wr_n   <= 1'b1;
      q.s3.rd_n   <= 1'b1;
      q.s3.wr_n   <= 1'b1;
      q.s1.io_read_cmd_n      <= 1'b1;
      q.s2.io_read_cmd_n      <= 1'b1;
      q.s3.io_read_cmd_n      <= 1'b1;
      q.s1.adv_io_write_cmd_n <= 1'b1;
      q.s2.adv_io_write_cmd_n <= 1'b1;
      q.s3.adv_io_write_cmd_n <= 1'b1;
      q.s1.cs_n   <= 1'b1;
      q.s2.cs_n   <= 1'b1;
      q.s3.cs_n   <= 1'b1;
      q.port.port_addr_strobe_n <= 1'b1;
      q.port.port_data_strobe_n <= 1'b1;
      q.port.port_chip_select_n <= 1'b1;
      q.st        <= ST_IDLE;
      q.ready     <= 1'b1;
      q.status    <= STATUS_RST;
      q.key_left  <= KEY_NONE;
    end else begin
      q <= d;
    end
  end

  // odd wait count pairs with the high-forcing synchroniser
  cma_clk_sync u_clk_sync (
    .clk        (clk),
    .arst_n     (arst_n),
    .cpu_lvl    (q.s2.cpu_clk),
    .cpu_fall   (cpu_fall),
    .rephase    (rephase),
    .odd_waits  (fast_host),
    .div_en     (clk_div_en),
    .cipher_clk (cipher_clk)
  );

  assign port_o           = q.port;
  assign host_ready       = q.ready;
  assign exp_status       = q.status;
  assign key_bytes_left   = q.key_left;
  assign soft_reset_pulse = q.rst_pulse;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_as_inverse: assert property (
    ##1 port_o.port_addr_strobe_n == !$past(q.s2.ale)
  ) else $error("address strobe is not inverted latch enable");

  a_ds_max_mode: assert property (
    !min_mode && !q.s2.io_read_cmd_n |=> !port_o.port_data_strobe_n
  ) else $error("data strobe missing for I/O read");

  a_ds_min_mode: assert property (
    min_mode && q.s2.rd_n && q.s2.wr_n |=> port_o.port_data_strobe_n
  ) else $error("data strobe active with no read or write");

  a_rw_follows: assert property (
    ##1 port_o.port_rw_dir == $past(q.s2.xmit_recv_dir)
  ) else $error("direction line does not follow transmit/receive");

  a_sel_latched: assert property (
    ale_fall |=> q.lat_sel == {$past(q.s2.a2), $past(q.s2.a1)}
  ) else $error("register select not captured");

  a_cs_latched: assert property (
    ale_fall |=> q.lat_cs == (!$past(q.s2.cs_n)
                 && !($past(min_mode) && $past(q.s2.m_io)))
  ) else $error("chip select not captured");

  a_mode_low: assert property (
    ##1 !port_o.ctl_key_mode_sel
  ) else $error("control/key mode select not low");

  a_wait_insert: assert property (
    q.st == ST_ADDR && !q.s2.ale && ds_now && q.lat_cs && fast_host
    |=> !host_ready ##0 q.st == ST_WAIT
  ) else $error("wait state not inserted");

  a_no_wait_slow: assert property (
    !fast_host && q.st != ST_WAIT |=> host_ready
  ) else $error("wait inserted on slow host");

  a_key_pending: assert property (
    our_write && q.lat_sel == SEL_CMD && q.s3.data == CMD_LOAD_KEY
    |=> exp_status == STAT_CMD_PEND && key_bytes_left == KEY_BYTES
  ) else $error("key command did not set pending");

  a_stop_clears: assert property (
    our_write && q.lat_sel == SEL_CMD && q.s3.data == CMD_STOP
    |=> exp_status == STAT_CLEAR
  ) else $error("stop command left status flags");

  a_soft_reset: assert property (
    our_write && q.lat_sel == SEL_CMD && q.s3.data == CMD_SOFT_RST
    |=> soft_reset_pulse ##1 !soft_reset_pulse
  ) else $error("software reset pulse wrong");

endmodule

/* cma_host_model.sv */
// host local bus model driving the adapter's host pins
`timescale 1ns/1ps
module cma_host_model
  import cma_pkg::*;
(
  // clock
  input  wire logic clk,
  // bus mode and handshake
  input  wire logic min_mode,
  input  wire logic host_ready,
  // host pins
  output cma_host_t host
);
  logic [7:0] last_d;
  // strobes idle, decoder off; cpu clock runs free
  initial begin
    host = 19'h1e400;
    last_d = 8'h00;
    forever begin
      repeat (4) @(negedge clk);
      host.cpu_clk = ~host.cpu_clk;
    end
  end
  // one whole bus cycle: address phase, strobe, release
  task automatic access(input logic wr, input logic [1:0] sel,
                        input logic [7:0] d, input logic mio);
    int n;
    n = 0;
    @(negedge clk);
    // decoder enabled in i/o cycles unless a scenario breaks it
    {host.ale, host.a2, host.a1, host.m_io} = {1'b1, sel, mio};
    {host.cs_n, host.xmit_recv_dir} = {1'b0, wr};
    // six cycles of latch pulse stay above the narrow strobe minimum
    repeat (6) @(negedge clk);
    host.ale = 1'b0;
    repeat (6) @(negedge clk);
    // a read never leaves the old byte on the lines
    host.data = wr ? d : ~last_d;
    {host.rd_n, host.wr_n} = min_mode ? {wr, !wr} : 2'h3;
    {host.io_read_cmd_n, host.adv_io_write_cmd_n} =
      min_mode ? 2'h3 : {wr, !wr};
    repeat (6) @(negedge clk);
    while (host_ready !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    // a ready line that never returns counts against the run
    tb_top.chk(8'(n < 64), 8'h01);
    {host.rd_n, host.wr_n} = 2'h3;
    {host.io_read_cmd_n, host.adv_io_write_cmd_n} = 2'h3;
    repeat (6) @(negedge clk);
    {host.cs_n, host.m_io} = 2'h2;
    last_d = host.data;
    host.data = ~host.data;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the cipher master port adapter
`timescale 1ns/1ps
module tb_top
  import cma_pkg::*;
;
  // clock, reset and straps
  logic       clk;
  logic       arst_n;
  logic       min_mode;
  logic       clk_div_en;
  logic       fast_host;
  // pins and outputs
  cma_host_t  host;
  cma_port_t  port;
  logic       cipher_clk;
  logic       host_ready;
  logic [7:0] exp_status;
  logic [3:0] key_bytes_left;
  logic       soft_reset_pulse;
  // bookkeeping
  int         n_mismatch;
  int         checks_done;
  int         n_pulse;
  int         n_wait;

  cma_adapter cma_adapter_i (
    .clk              (clk),
    .arst_n           (arst_n),
    .host_i           (host),
    .min_mode         (min_mode),
    .clk_div_en       (clk_div_en),
    .fast_host        (fast_host),
    .port_o           (port),
    .cipher_clk       (cipher_clk),
    .host_ready       (host_ready),
    .exp_status       (exp_status),
    .key_bytes_left   (key_bytes_left),
    .soft_reset_pulse (soft_reset_pulse)
  );

  cma_host_model cma_host_model_i (
    .clk        (clk),
    .min_mode   (min_mode),
    .host_ready (host_ready),
    .host       (host)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulse and wait cycles seen at the outputs
  always @(negedge clk) begin
    if (soft_reset_pulse === 1'b1) n_pulse++;
    if (host_ready === 1'b0) n_wait++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    cma_host_model_i.access(1'b1, sel, d, 1'b0);
  endtask

  task automatic t_reset();
    chk({1'b0, port}, 8'h68);
    chk({cipher_clk, host_ready, 2'h0, key_bytes_left}, 8'h40);
    chk(exp_status, STATUS_RST);
  endtask

  // both modes, both directions, one memory cycle in minimum mode
  task automatic t_pins();
    logic [2:0] i;
    for (int j = 0; j < 6; j++) begin
      i = 3'(j);
      min_mode = i[0];
      fork
        cma_host_model_i.access(i[1], {i[0], 1'b0}, 8'h5a, j == 5);
        begin
          repeat (5) @(negedge clk);
          chk({1'b0, port.port_addr_strobe_n, port.port_rw_dir,
               port.ctl_key_mode_sel, port.reg_sel_bit2,
               port.reg_sel_bit1, 2'h0},
              {2'h0, i[1], 1'b0, i[0], 3'h0});
          repeat (6) @(negedge clk);
          chk({6'h0, port.port_addr_strobe_n, port.port_chip_select_n},
              {6'h0, 1'b1, j == 5});
          repeat (6) @(negedge clk);
          if (j < 5) chk(8'(port.port_data_strobe_n), 8'h00);
        end
      join
      chk(8'(port.port_data_strobe_n), 8'h01);
    end
  endtask

  // cipher clock period in ns, idle bus
  task automatic t_clk(input logic div, input logic [7:0] per);
    time t0;
    clk_div_en = div;
    repeat (40) @(negedge clk);
    @(posedge cipher_clk);
    t0 = $time;
    @(posedge cipher_clk);
    chk(8'($time - t0), per);
    @(negedge clk);
  endtask

  // wait cycles must fall in 1 to 12 for a read and for a write, and be none on a slow host
  task automatic t_wait();
    fast_host = 1'b1;
    n_wait = 0;
    cma_host_model_i.access(1'b0, SEL_CMD, 8'h00, 1'b0);
    chk(8'(n_wait inside {[1:12]}), 8'h01);
    n_wait = 0;
    wr(SEL_DATA, 8'h33);
    chk(8'(n_wait inside {[1:12]}), 8'h01);
    fast_host = 1'b0;
    n_wait = 0;
    wr(SEL_DATA, 8'h33);
    chk(8'(n_wait), 8'h00);
  endtask

  task automatic t_session();
    int p0;
    p0 = n_pulse;
    wr(SEL_CMD, CMD_SOFT_RST);
    chk(8'(n_pulse - p0), 8'h01);
    chk(exp_status, STAT_CLEAR);
    wr(SEL_CMD, CMD_LOAD_KEY);
    chk(exp_status, STAT_CMD_PEND);
    chk(8'(key_bytes_left), 8'h08);
    // a status read must not disturb the pending status
    cma_host_model_i.access(1'b0, SEL_CMD, 8'h00, 1'b0);
    chk(exp_status, STAT_CMD_PEND);
    // busy clear before a data read; a read must not use up a key byte
    chk(exp_status & STAT_BUSY, 8'h00);
    cma_host_model_i.access(1'b0, SEL_DATA, 8'h00, 1'b0);
    chk(8'(key_bytes_left), 8'h08);
    for (int k = 0; k < 8; k++) begin
      wr(SEL_DATA, k == 0 ? 8'h80 : 8'h01);
      chk(8'(key_bytes_left), 8'(7 - k));
      chk(exp_status, k == 7 ? 8'h00 : 8'h40);
    end
    wr(SEL_CMD, CMD_LOAD_KEY);
    wr(SEL_CMD, CMD_STOP);
    chk(exp_status, STAT_CLEAR);
    chk(8'(key_bytes_left), 8'h00);
  endtask

  initial begin
    {arst_n, min_mode, clk_div_en, fast_host} = 4'h6;
    repeat (9) @(negedge clk);
    t_reset();
    @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_pins();
    t_clk(1'b1, 8'h80);
    t_clk(1'b0, 8'h40);
    clk_div_en = 1'b1;
    t_wait();
    t_session();
    stop_test();
  end

  // hang guard, far beyond the several hundred cycles of the tests
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule
